// ---- pmds_pkg.sv ----
/*
 Shared constants and types for the monitor access status block.
 Assumes one clock domain and a synchronous, active high reset.
*/
package pmds_pkg;

	// ------------------------------------------------------------
	// Field positions in the processor debug status word
	// ------------------------------------------------------------
	localparam int unsigned STATUS_WIDTH         = 32;
	localparam int unsigned STICKY_ERROR_BIT     = 10;
	localparam int unsigned DISABLE_STATUS_BIT   = 9;
	localparam int unsigned DISABLE_EXTENDED_BIT = 16;

	// ------------------------------------------------------------
	// Values after reset and for reads that return an unknown value
	// ------------------------------------------------------------
	localparam logic        STICKY_RESET    = 1'b0;
	localparam logic        DISABLE_RESET   = 1'b0;
	localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;
	localparam logic [31:0] UNKNOWN_READ    = 32'h0000_0000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SEC_SECURE,
		SEC_NON_SECURE,
		SEC_ROOT,
		SEC_REALM
	} pmds_sec_state_t;

	typedef struct packed {
		logic core_power_up;
		logic double_lock_active;
		logic software_lock_active;
		logic os_lock_active;
		logic core_in_reset_status;
	} pmds_lock_status_t;

	typedef struct packed {
		logic root;
		logic realm;
		logic secure;
		logic non_secure;
	} pmds_permit_t;

	typedef struct packed {
		logic            refused;
		pmds_sec_state_t state;
	} pmds_refusal_t;

endpackage

// ---- pmds_status.sv ----
/*
 Monitor access error and disable status fields of the processor debug status register.
 Assumes lock, power and permission inputs come from logic on clk_i, and that the
 debug access port delivers one-cycle read and write strobes on the same clock.
*/
`timescale 1ns/100ps

module pmds_status #(
	parameter bit PERF_MONITOR_FEATURE    = 1'b1,
	parameter bit NEWER_DEBUG_FEATURE     = 1'b1,
	parameter bit REALM_EXTENSION_FEATURE = 1'b1,
	parameter bit POWERDOWN_DEBUG_FEATURE = 1'b0,
	parameter bit DOUBLE_LOCK_FEATURE     = 1'b1
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire pmds_pkg::pmds_lock_status_t lock_status_i,
	input  wire pmds_pkg::pmds_permit_t     monitor_external_access_allowed_i,
	input  wire pmds_pkg::pmds_refusal_t    refusal_i,
	input  wire logic                       status_rd_i,
	input  wire logic                       status_wr_i,
	output logic [31:0]                     status_rdata_o,
	output logic                            status_rvalid_o,
	output logic                            sticky_monitor_access_error_o,
	output logic                            monitor_access_disable_status_o,
	output logic                            monitor_access_disable_extended_o
);

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic access_unknown(input pmds_pkg::pmds_lock_status_t ls);
		logic unk;
		unk = ls.double_lock_active && DOUBLE_LOCK_FEATURE;
		unk = unk || (!POWERDOWN_DEBUG_FEATURE && !ls.core_power_up);
		unk = unk || ls.core_in_reset_status;
		unk = unk || (!NEWER_DEBUG_FEATURE && ls.os_lock_active);
		return unk;
	endfunction

	function automatic logic [1:0] encode_disable(input pmds_pkg::pmds_permit_t p);
		logic [1:0] enc;
		if (REALM_EXTENSION_FEATURE) begin
			// Root is permitted in every code, so its flag is never looked at.
			if (p.realm && p.secure && p.non_secure) begin
				enc = 2'b00;
			end else if (p.secure && !p.realm) begin
				enc = 2'b01;
			end else if (p.realm && !p.secure) begin
				enc = 2'b10;
			end else begin
				enc = 2'b11;
			end
		end else begin
			enc = {1'b0, !p.non_secure};
		end
		return enc;
	endfunction

	// ------------------------------------------------------------
	// Status state
	// ------------------------------------------------------------
	logic        sticky_q;
	logic        sticky_d;
	logic        dis_q;
	logic        dis_d;
	logic        ext_q;
	logic        ext_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        rvalid_q;
	logic        rvalid_d;
	logic        unknown;
	logic        set_ev;
	logic        clear_ev;
	logic [1:0]  enc;

	always_comb begin
		unknown = access_unknown(lock_status_i);
		enc     = encode_disable(monitor_external_access_allowed_i);
		// The Non-secure filter applies only at the newer level.
		set_ev  = PERF_MONITOR_FEATURE && refusal_i.refused &&
		          (!NEWER_DEBUG_FEATURE || refusal_i.state == pmds_pkg::SEC_NON_SECURE);
		// Keeping the bit under double lock avoids losing an error that the debugger
		// could not yet see, since such a read returns an unknown value anyway.
		clear_ev = status_rd_i && lock_status_i.core_power_up && !unknown &&
		           !lock_status_i.software_lock_active;
		sticky_d = sticky_q;
		if (set_ev) begin
			sticky_d = 1'b1;
		end else if (clear_ev) begin
			sticky_d = 1'b0;
		end
		dis_d = PERF_MONITOR_FEATURE && enc[0];
		ext_d = PERF_MONITOR_FEATURE && REALM_EXTENSION_FEATURE && enc[1];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sticky_q <= pmds_pkg::STICKY_RESET;
			dis_q    <= pmds_pkg::DISABLE_RESET;
			ext_q    <= pmds_pkg::DISABLE_RESET;
		end else begin
			sticky_q <= sticky_d;
			dis_q    <= dis_d;
			ext_q    <= ext_d;
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Writes are ignored in every state, so status_wr_i changes nothing.
	always_comb begin
		rvalid_d = status_rd_i;
		rdata_d  = rdata_q;
		if (status_rd_i) begin
			rdata_d = pmds_pkg::UNKNOWN_READ;
			if (!unknown && !(status_wr_i && 1'b0)) begin
				rdata_d[pmds_pkg::STICKY_ERROR_BIT]     = sticky_q;
				rdata_d[pmds_pkg::DISABLE_STATUS_BIT]   = dis_q;
				rdata_d[pmds_pkg::DISABLE_EXTENDED_BIT] = ext_q;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q  <= pmds_pkg::RDATA_RESET;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign status_rdata_o                    = rdata_q;
	assign status_rvalid_o                   = rvalid_q;
	assign sticky_monitor_access_error_o     = sticky_q;
	assign monitor_access_disable_status_o   = dis_q;
	assign monitor_access_disable_extended_o = ext_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sticky_set_a: assert property (
		PERF_MONITOR_FEATURE && refusal_i.refused &&
		(!NEWER_DEBUG_FEATURE || refusal_i.state == pmds_pkg::SEC_NON_SECURE)
		|=> sticky_q)
		else $error("refused access did not set sticky bit");

	ns_filter_a: assert property (
		NEWER_DEBUG_FEATURE && !sticky_q && !status_rd_i && refusal_i.refused &&
		refusal_i.state != pmds_pkg::SEC_NON_SECURE
		|=> !sticky_q)
		else $error("non Non-secure refusal set sticky bit");

	any_state_a: assert property (
		!NEWER_DEBUG_FEATURE && PERF_MONITOR_FEATURE && refusal_i.refused
		|=> sticky_q ##1 (sticky_q || $past(status_rd_i)))
		else $error("refusal lost without newer level");

	read_clear_a: assert property (
		status_rd_i && !refusal_i.refused && lock_status_i.core_power_up &&
		!access_unknown(lock_status_i) && !lock_status_i.software_lock_active
		|=> !sticky_q && status_rvalid_o)
		else $error("status read did not clear sticky bit");

	dlock_hold_a: assert property (
		DOUBLE_LOCK_FEATURE && lock_status_i.double_lock_active && sticky_q
		|=> sticky_q)
		else $error("sticky bit changed under double lock");

	swlock_hold_a: assert property (
		lock_status_i.software_lock_active && sticky_q && status_rd_i
		|=> sticky_q [*1] ##0 (status_rdata_o[pmds_pkg::STICKY_ERROR_BIT] ||
		$past(unknown)))
		else $error("read cleared sticky bit under software lock");

	reset_zero_a: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> !sticky_q && !status_rvalid_o)
		else $error("sticky bit not zero after reset");

	unknown_read_a: assert property (
		status_rd_i && access_unknown(lock_status_i)
		|=> status_rvalid_o && status_rdata_o == pmds_pkg::UNKNOWN_READ)
		else $error("read under lock returned field values");

	encode_a: assert property (
		REALM_EXTENSION_FEATURE && PERF_MONITOR_FEATURE &&
		monitor_external_access_allowed_i.secure && !monitor_external_access_allowed_i.realm
		|=> !ext_q && dis_q)
		else $error("Root and Secure encoding wrong");

	ns_disable_a: assert property (
		!REALM_EXTENSION_FEATURE && PERF_MONITOR_FEATURE
		|=> dis_q == !$past(monitor_external_access_allowed_i.non_secure) && !ext_q)
		else $error("disable status does not follow permission");

	read_field_a: assert property (
		status_rd_i && !access_unknown(lock_status_i)
		|=> status_rdata_o[pmds_pkg::DISABLE_EXTENDED_BIT] == $past(ext_q) &&
		status_rdata_o[pmds_pkg::DISABLE_STATUS_BIT] == $past(dis_q) &&
		status_rdata_o[31:17] == 15'h0000)
		else $error("read data fields wrong");

	set_wins_a: assert property (
		PERF_MONITOR_FEATURE && refusal_i.refused && status_rd_i &&
		(!NEWER_DEBUG_FEATURE || refusal_i.state == pmds_pkg::SEC_NON_SECURE)
		|=> sticky_q)
		else $error("clearing read beat a refusal");

endmodule

// ---- pmds_debugger.sv ----
/*
 Behavioural external debugger that raises refused monitor accesses and status reads.
 Assumes the bench calls issue just after a rising edge of clk_i, once per cycle.
*/
`timescale 1ns/100ps

module pmds_debugger (
	input  wire logic             clk_i,
	output pmds_pkg::pmds_refusal_t refusal_o,
	output logic                  status_rd_o,
	output logic                  status_wr_o
);
	initial begin
		refusal_o = '0;
		status_rd_o = 1'b0;
		status_wr_o = 1'b0;
	end

	// ------------------------------------------------------------
	// Request driver
	// ------------------------------------------------------------
	// Strobes last one cycle because the next call replaces them.
	task automatic issue(input logic refv, input pmds_pkg::pmds_sec_state_t st,
			input logic rd, input logic wr);
		refusal_o.refused = refv;
		refusal_o.state = st;
		status_rd_o = rd;
		status_wr_o = wr;
	endtask
endmodule

// ---- testbench.sv ----
/*
 Self-checking bench for the monitor access status block with a cycle reference model.
 Assumes a 40 MHz clock; one instance keeps the default feature parameters, two drop
 the realm extension, and of those one also lacks the newer debug level.
*/
`timescale 1ns/100ps

module testbench;
	logic                        clk_i = 1'b0;
	logic                        rst_i = 1'b1;
	pmds_pkg::pmds_lock_status_t lock_s = 5'h10;
	pmds_pkg::pmds_permit_t      permit = 4'hf;
	pmds_pkg::pmds_refusal_t     refusal;
	logic                        rd;
	logic                        wr;
	logic [31:0]                 rdata;
	logic                        rvalid;
	logic                        sticky;
	logic                        dis;
	logic                        ext;
	logic [35:0]                 exp_v = 36'h0_0000_0000;
	logic [35:0]                 exp_n = 36'h0_0000_0000;
	logic [35:0]                 exp_o = 36'h0_0000_0000;
	wire logic [35:0]            got_n;
	wire logic [35:0]            got_o;
	logic [31:0]                 seed = 32'h0000_000b;
	int                          err_count = 0;
	int                          comparisons = 0;

	always #12.5 clk_i = ~clk_i;

	pmds_status DUT (
		.clk_i                            (clk_i),
		.rst_i                            (rst_i),
		.lock_status_i                    (lock_s),
		.monitor_external_access_allowed_i(permit),
		.refusal_i                        (refusal),
		.status_rd_i                      (rd),
		.status_wr_i                      (wr),
		.status_rdata_o                   (rdata),
		.status_rvalid_o                  (rvalid),
		.sticky_monitor_access_error_o    (sticky),
		.monitor_access_disable_status_o  (dis),
		.monitor_access_disable_extended_o(ext)
	);

	pmds_status #(
		.NEWER_DEBUG_FEATURE    (1'b1),
		.REALM_EXTENSION_FEATURE(1'b0)
	) dut_no_realm (
		.clk_i                            (clk_i),
		.rst_i                            (rst_i),
		.lock_status_i                    (lock_s),
		.monitor_external_access_allowed_i(permit),
		.refusal_i                        (refusal),
		.status_rd_i                      (rd),
		.status_wr_i                      (wr),
		.status_rdata_o                   (got_n[31:0]),
		.status_rvalid_o                  (got_n[35]),
		.sticky_monitor_access_error_o    (got_n[32]),
		.monitor_access_disable_status_o  (got_n[33]),
		.monitor_access_disable_extended_o(got_n[34])
	);

	pmds_status #(
		.NEWER_DEBUG_FEATURE    (1'b0),
		.REALM_EXTENSION_FEATURE(1'b0)
	) dut_older (
		.clk_i                            (clk_i),
		.rst_i                            (rst_i),
		.lock_status_i                    (lock_s),
		.monitor_external_access_allowed_i(permit),
		.refusal_i                        (refusal),
		.status_rd_i                      (rd),
		.status_wr_i                      (wr),
		.status_rdata_o                   (got_o[31:0]),
		.status_rvalid_o                  (got_o[35]),
		.sticky_monitor_access_error_o    (got_o[32]),
		.monitor_access_disable_status_o  (got_o[33]),
		.monitor_access_disable_extended_o(got_o[34])
	);

	pmds_debugger u_dbg (
		.clk_i      (clk_i),
		.refusal_o  (refusal),
		.status_rd_o(rd),
		.status_wr_o(wr)
	);

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// Returns the extended bit above the disable bit; Root is allowed in every code.
	function automatic logic [1:0] perm_code(input pmds_pkg::pmds_permit_t p);
		if (p.realm && p.secure && p.non_secure) return 2'h0;
		if (p.secure && !p.realm) return 2'h1;
		if (p.realm && !p.secure) return 2'h2;
		return 2'h3;
	endfunction

	// Expected {rvalid, ext, dis, sticky, rdata} after the edge that samples ev.
	function automatic logic [35:0] nxt(input logic [35:0] e, input logic [5:0] ev,
			input logic newer, input logic realm);
		logic        unk;
		logic        clr;
		logic [35:0] n;
		unk = lock_s.double_lock_active || !lock_s.core_power_up ||
			lock_s.core_in_reset_status || (!newer && lock_s.os_lock_active);
		clr = ev[3] && !unk && !lock_s.software_lock_active;
		n = e;
		n[35] = ev[3];
		if (ev[3])
			n[31:0] = unk ? 32'h0000_0000 : {15'h0000, e[34], 5'h00, e[32], e[33], 9'h000};
		if (ev[0] && (!newer ||
				pmds_pkg::pmds_sec_state_t'(ev[2:1]) == pmds_pkg::SEC_NON_SECURE))
			n[32] = 1'b1;
		else if (clr)
			n[32] = 1'b0;
		n[34:33] = realm ? perm_code(permit) : {1'b0, !permit.non_secure};
		if (rst_i)
			n = 36'h0_0000_0000;
		return n;
	endfunction

	task automatic close_out();
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// One cycle: compare, drive the next inputs, advance the models
	// ------------------------------------------------------------
	// Permission only moves on cycles without a read, so a read never sees it in flight.
	task automatic cyc(input logic [4:0] l, input logic [3:0] p, input logic [5:0] ev);
		@(posedge clk_i);
		#1;
		comparisons++;
		if ({rvalid, ext, dis, sticky, rdata} !== exp_v) begin
			err_count++;
			$display("mismatch %0t status got %h want %h", $time,
				{rvalid, ext, dis, sticky, rdata}, exp_v);
		end
		comparisons++;
		if (got_n !== exp_n) begin
			err_count++;
			$display("mismatch %0t no realm status got %h want %h", $time, got_n, exp_n);
		end
		comparisons++;
		if (got_o !== exp_o) begin
			err_count++;
			$display("mismatch %0t older level status got %h want %h", $time, got_o, exp_o);
		end
		lock_s = l;
		if (!ev[3])
			permit = p;
		rst_i = ev[5];
		u_dbg.issue(ev[0], pmds_pkg::pmds_sec_state_t'(ev[2:1]), ev[3], ev[4]);
		exp_v = nxt(exp_v, ev, 1'b1, 1'b1);
		exp_n = nxt(exp_n, ev, 1'b1, 1'b0);
		exp_o = nxt(exp_o, ev, 1'b0, 1'b0);
	endtask

	initial begin
		repeat (5) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		cyc(5'h10, 4'hf, 6'h03);
		cyc(5'h10, 4'hf, 6'h08);
		cyc(5'h10, 4'hf, 6'h01);
		cyc(5'h10, 4'hf, 6'h05);
		cyc(5'h10, 4'hf, 6'h07);
		cyc(5'h10, 4'hf, 6'h0b);
		cyc(5'h14, 4'hf, 6'h08);
		cyc(5'h18, 4'hf, 6'h18);
		cyc(5'h11, 4'hf, 6'h08);
		cyc(5'h00, 4'hf, 6'h08);
		cyc(5'h12, 4'hf, 6'h08);
		cyc(5'h10, 4'hf, 6'h13);
		cyc(5'h10, 4'hf, 6'h20);
		for (int i = 0; i < 16; i++) begin
			cyc(5'h10, i[3:0], 6'h00);
			cyc(5'h10, i[3:0], 6'h08);
		end
		for (int i = 0; i < 3000; i++) begin
			seed = xs(seed);
			cyc({seed[12] | seed[13], seed[3:0] & seed[7:4] & seed[11:8]}, seed[27:24],
				{seed[31:28] == 4'h0, seed[20:16]});
		end
		cyc(5'h10, 4'hf, 6'h00);
		close_out();
	end
endmodule
